// File: paso_params.svh
// constants of the sample output block: widths, codes, depths and reset values
// How it works
// - sample clock rise puts converter into hold
// - coarse result first, then fine result
// - correct and align both results into one word
// - result leaves as one ten bit word
// - msb on highest line, lsb on lowest
// - word and flag change on sample edge
// - word belongs to sample five edges earlier
// - flag low in span, high outside it
// - over gives ones, under zeros, both flagged
// - out of span holds word at a rail
`ifndef PASO_PARAMS_SVH
`define PASO_PARAMS_SVH

`define PASO_CLK_PERIOD_NS 50
`define PASO_WORD_W 10
`define PASO_COARSE_W 5
`define PASO_FINE_W 6
`define PASO_FINE_OFFSET 12'sh010
`define PASO_WORD_MAX 10'h3ff
`define PASO_WORD_MIN 10'h000
`define PASO_MIDSCALE 10'h1ff
`define PASO_PIPE_DEPTH 5
`define PASO_FIFO_DEPTH 16
`define PASO_MIN_EDGE_GAP 4
`define PASO_RESULT_RST 11'h000
`define PASO_CODE_RST 5'h00
`define PASO_FINE_RST 6'h00

`endif

// File: paso_pkg.sv
// types shared by the sample output block
`include "paso_params.svh"

package paso_pkg;

	typedef logic [`PASO_WORD_W-1:0] paso_word_t;

	typedef struct packed {
		logic flag;
		paso_word_t word;
	} paso_result_t;

	typedef enum logic [3:0] {
		PASO_IDLE = 4'b0001,
		PASO_COARSE = 4'b0010,
		PASO_FINE = 4'b0100,
		PASO_CORRECT = 4'b1000
	} paso_conv_t;

	typedef struct packed {
		logic clk_seen;
		paso_conv_t conv;
		logic hold;
		logic coarse_go;
		logic fine_go;
		logic [`PASO_COARSE_W-1:0] coarse;
		logic [`PASO_FINE_W-1:0] fine;
		logic over;
		logic under;
		paso_result_t result;
		logic push;
		logic lost;
	} paso_state_t;

endpackage : paso_pkg

// File: paso_stage.sv
// one pipeline delay that advances on each sample edge
`timescale 1ns/10ps
module paso_stage #(
	parameter int WIDTH = 11
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic advance,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	typedef struct packed {
		logic [WIDTH-1:0] data;
	} paso_stage_t;

	paso_stage_t st;
	paso_stage_t next_st;

	always_comb begin
		next_st = st;
		if (advance) begin
			next_st.data = din;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.data;

endmodule : paso_stage

// File: paso_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
module paso_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} paso_fifo_t;

	paso_fifo_t st;
	paso_fifo_t next_st;
	logic do_push;
	logic do_pop;

	assign in_ready = (st.count != (AW+1)'(DEPTH));
	assign out_valid = (st.count != '0);
	assign out_data = st.mem[st.rd];
	assign do_push = in_valid && in_ready;
	assign do_pop = out_valid && out_ready;

	always_comb begin
		next_st = st;
		if (do_push) begin
			next_st.mem[st.wr] = in_data;
			next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + AW'(1);
		end
		if (do_pop) begin
			next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + AW'(1);
		end
		case ({do_push, do_pop})
			2'b10: next_st.count = st.count + (AW+1)'(1);
			2'b01: next_st.count = st.count - (AW+1)'(1);
			default: next_st.count = st.count;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	fifo_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("fifo head changed while stalled");
	fifo_full_a: assert property (!in_ready |-> st.count == (AW+1)'(DEPTH))
		else $error("fifo refuses while not full");

endmodule : paso_fifo

// File: paso_adc_out.sv
// converter digital side: conversion sequencing, correction, output pipeline and stream tap
`timescale 1ns/10ps
`include "paso_params.svh"
module paso_adc_out
	import paso_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic sample_clk,
	input wire logic over_top,
	input wire logic under_bottom,
	input wire logic [`PASO_COARSE_W-1:0] coarse_code,
	input wire logic [`PASO_FINE_W-1:0] fine_code,
	output logic track_hold,
	output logic coarse_go,
	output logic fine_go,
	output logic [`PASO_WORD_W-1:0] sample_word,
	output logic sample_bit_top,
	output logic range_flag,
	output logic [`PASO_WORD_W:0] stream_data,
	output logic stream_valid,
	input wire logic stream_ready,
	output logic stream_room,
	input wire logic stream_lost_clear,
	output logic stream_lost
);

	paso_state_t st;
	paso_state_t next_st;
	logic sample_edge;
	logic fifo_in_ready;
	paso_result_t chain [0:`PASO_PIPE_DEPTH];

	// coarse carries the upper bits; fine overlaps it by one bit and is offset
	// by half a coarse step, so a coarse code one step off is repaired here
	function automatic paso_result_t paso_fix(
		input logic [`PASO_COARSE_W-1:0] c,
		input logic [`PASO_FINE_W-1:0] f,
		input logic ov,
		input logic un
	);
		logic signed [11:0] sum;
		paso_result_t r;
		sum = $signed({2'b00, c, 5'h00}) + $signed({6'h00, f}) - `PASO_FINE_OFFSET;
		r.flag = 1'b0;
		r.word = `PASO_WORD_MIN;
		if (ov) begin
			r.flag = 1'b1;
			r.word = `PASO_WORD_MAX;
		end else if (un) begin
			r.flag = 1'b1;
			r.word = `PASO_WORD_MIN;
		end else if (sum < 12'sh000) begin
			r.word = `PASO_WORD_MIN;
		end else if (sum > $signed({2'b00, `PASO_WORD_MAX})) begin
			r.word = `PASO_WORD_MAX;
		end else begin
			r.word = sum[`PASO_WORD_W-1:0];
		end
		return r;
	endfunction : paso_fix

	// sample clock is synchronous to clock; a rise is one cycle wide
	assign sample_edge = sample_clk && !st.clk_seen;

	always_comb begin
		next_st = st;
		next_st.clk_seen = sample_clk;
		next_st.coarse_go = 1'b0;
		next_st.fine_go = 1'b0;
		next_st.push = sample_edge;
		if (sample_edge) begin
			// an early edge restarts the conversion
			next_st.conv = PASO_COARSE;
			next_st.hold = 1'b1;
			next_st.over = over_top;
			next_st.under = under_bottom;
			next_st.coarse_go = 1'b1;
		end else begin
			case (st.conv)
				PASO_IDLE: begin
					next_st.hold = 1'b0;
				end
				PASO_COARSE: begin
					next_st.coarse = coarse_code;
					next_st.fine_go = 1'b1;
					next_st.conv = PASO_FINE;
				end
				PASO_FINE: begin
					next_st.fine = fine_code;
					next_st.conv = PASO_CORRECT;
				end
				PASO_CORRECT: begin
					next_st.result = paso_fix(st.coarse, st.fine, st.over, st.under);
					next_st.hold = 1'b0;
					next_st.conv = PASO_IDLE;
				end
				default: begin
					next_st.conv = PASO_IDLE;
					next_st.hold = 1'b0;
				end
			endcase
		end
		// overflow of the tap wins over a clear in the same cycle
		next_st.lost = (st.lost && !stream_lost_clear) || (st.push && !fifo_in_ready);
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st.clk_seen <= 1'b0;
			st.conv <= PASO_IDLE;
			st.hold <= 1'b0;
			st.coarse_go <= 1'b0;
			st.fine_go <= 1'b0;
			st.coarse <= `PASO_CODE_RST;
			st.fine <= `PASO_FINE_RST;
			st.over <= 1'b0;
			st.under <= 1'b0;
			st.result <= `PASO_RESULT_RST;
			st.push <= 1'b0;
			st.lost <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// the finished result of the previous sample enters the first delay on
	// each edge; five delays in all put it on the pins five edges after its sample
	assign chain[0] = st.result;

	genvar gi;
	generate
		for (gi = 0; gi < `PASO_PIPE_DEPTH; gi++) begin : g_pipe
			paso_stage #(
				.WIDTH($bits(paso_result_t))
			) u_stage (
				.clock(clock),
				.rstn(rstn),
				.advance(sample_edge),
				.din(chain[gi]),
				.dout(chain[gi+1])
			);
		end
	endgenerate

	assign sample_word = chain[`PASO_PIPE_DEPTH].word;
	assign sample_bit_top = chain[`PASO_PIPE_DEPTH].word[`PASO_WORD_W-1];
	assign range_flag = chain[`PASO_PIPE_DEPTH].flag;
	assign track_hold = st.hold;
	assign coarse_go = st.coarse_go;
	assign fine_go = st.fine_go;
	assign stream_lost = st.lost;
	assign stream_room = fifo_in_ready;

	// each word that reaches the pins is also queued while the fifo has room, flag on top
	paso_fifo #(
		.WIDTH($bits(paso_result_t)),
		.DEPTH(`PASO_FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rstn(rstn),
		.in_valid(st.push),
		.in_ready(fifo_in_ready),
		.in_data(chain[`PASO_PIPE_DEPTH]),
		.out_valid(stream_valid),
		.out_ready(stream_ready),
		.out_data(stream_data)
	);

	// helper: reference chain of result flags, moved on every sample edge
	logic [`PASO_PIPE_DEPTH-1:0] ref_flag;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ref_flag <= '0;
		end else if (sample_edge) begin
			ref_flag <= {ref_flag[`PASO_PIPE_DEPTH-2:0], st.result.flag};
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence coarse_step;
		coarse_go && !fine_go && track_hold;
	endsequence

	sequence fine_step;
		fine_go && !coarse_go && track_hold;
	endsequence

	sequence correct_step;
		st.conv == PASO_CORRECT && track_hold && !coarse_go && !fine_go;
	endsequence

	property two_step_p;
		sample_edge |=> coarse_step ##1 fine_step;
	endproperty

	property conv_order_p;
		sample_edge |=> coarse_step ##1 fine_step ##1 correct_step ##1 !track_hold;
	endproperty

	hold_on_edge_a: assert property (sample_edge |=> track_hold [*3] ##1 !track_hold)
		else $error("hold not held for the conversion");
	coarse_fine_a: assert property (two_step_p)
		else $error("coarse and fine steps out of order");
	// conversion sequencing
	hold_rise_a: assert property ($rose(track_hold) |-> $past(sample_edge))
		else $error("hold entered without a sample edge");
	hold_drop_a: assert property (st.conv == PASO_CORRECT && !sample_edge |=> !track_hold)
		else $error("hold kept after the correct step");
	idle_track_a: assert property (st.conv == PASO_IDLE && !sample_edge |=> !track_hold)
		else $error("hold kept while idle");

	conv_order_a: assert property (conv_order_p)
		else $error("conversion steps out of order");
	conv_onehot_a: assert property ($onehot(st.conv))
		else $error("conversion state not one-hot");
	coarse_single_a: assert property (coarse_go |=> !coarse_go)
		else $error("coarse go longer than one cycle");
	fine_single_a: assert property (fine_go |=> !fine_go)
		else $error("fine go longer than one cycle");
	fine_after_a: assert property (fine_go |-> $past(coarse_go))
		else $error("fine step without coarse step");
	coarse_latch_a: assert property (coarse_go |=> st.coarse == $past(coarse_code))
		else $error("coarse code not taken");
	fine_latch_a: assert property (fine_go |=> st.fine == $past(fine_code))
		else $error("fine code not taken");
	coarse_keep_a: assert property (st.conv != PASO_COARSE |=> $stable(st.coarse))
		else $error("coarse code moved outside its step");
	fine_keep_a: assert property (st.conv != PASO_FINE |=> $stable(st.fine))
		else $error("fine code moved outside its step");

	// correction and coding
	correct_clamp_a: assert property (st.conv == PASO_CORRECT && !st.over && !st.under
		&& st.coarse == 5'h00 && st.fine < 6'h10 |=> st.result.word == `PASO_WORD_MIN)
		else $error("negative corrected sum not clamped");
	high_clamp_a: assert property (st.conv == PASO_CORRECT && !st.over && !st.under
		&& st.coarse == 5'h1f && st.fine >= 6'h2f |=> st.result.word == `PASO_WORD_MAX)
		else $error("corrected sum above full scale not clamped");
	result_still_a: assert property (st.conv != PASO_CORRECT |=> $stable(st.result))
		else $error("result changed outside the correct step");
	flag_clear_a: assert property (st.conv == PASO_CORRECT && !st.over && !st.under
		|=> !st.result.flag)
		else $error("flag set for in-span input");
	flag_set_a: assert property (st.conv == PASO_CORRECT && (st.over || st.under)
		|=> st.result.flag)
		else $error("flag clear for out-of-span input");
	over_code_a: assert property (sample_edge && over_top |=> ##3
		st.result == {1'b1, `PASO_WORD_MAX})
		else $error("over range code wrong");
	under_code_a: assert property (sample_edge && under_bottom && !over_top |=> ##3
		st.result == {1'b1, `PASO_WORD_MIN})
		else $error("under range code wrong");
	mid_code_a: assert property (st.conv == PASO_CORRECT && !st.over && !st.under
		&& st.coarse == 5'h0f && st.fine == 6'h2f |=> st.result.word == `PASO_MIDSCALE)
		else $error("midscale code wrong");
	range_latch_a: assert property (sample_edge |=> st.over == $past(over_top)
		&& st.under == $past(under_bottom))
		else $error("range comparators not latched at the edge");
	range_keep_a: assert property (!sample_edge |=> $stable({st.over, st.under}))
		else $error("range latch moved between edges");
	rail_hold_a: assert property (range_flag |-> sample_word == `PASO_WORD_MAX
		|| sample_word == `PASO_WORD_MIN)
		else $error("flagged word not at a rail");
	rail_under_a: assert property (range_flag && !sample_bit_top |-> sample_word == `PASO_WORD_MIN)
		else $error("flagged low word not at zero");

	// output pipeline and tap
	stream_word_a: assert property (st.push && stream_room && !stream_valid
		|=> stream_valid && stream_data == $past({range_flag, sample_word}))
		else $error("queued word differs from pin word");
	top_bit_a: assert property (sample_bit_top == (sample_word > `PASO_MIDSCALE))
		else $error("msb line mismatch");
	out_on_edge_a: assert property (!$stable({range_flag, sample_word}) |-> $past(sample_edge))
		else $error("output changed without sample edge");
	word_still_a: assert property (!sample_edge |=> $stable(chain[`PASO_PIPE_DEPTH]))
		else $error("pin word moved between sample edges");
	push_on_edge_a: assert property (st.push |-> $past(sample_edge))
		else $error("tap push without a pin update");
	lost_set_a: assert property (st.push && !stream_room |=> stream_lost)
		else $error("dropped pin word not flagged");
	lost_keep_a: assert property (stream_lost && !stream_lost_clear |=> stream_lost)
		else $error("lost flag fell without a clear");
	lost_clear_a: assert property (stream_lost && stream_lost_clear
		&& !(st.push && !stream_room) |=> !stream_lost)
		else $error("lost flag not cleared");
	pipe_latency_a: assert property (sample_edge |=> range_flag == ref_flag[`PASO_PIPE_DEPTH-1])
		else $error("flag latency is not five edges");
	stage_shift_a: assert property (sample_edge |=> chain[1] == $past(chain[0]))
		else $error("first delay did not take the finished result");

endmodule : paso_adc_out

// File: paso_capture.sv
// capture partner: makes sample clock bursts and registers word and flag
`timescale 1ns/10ps
module paso_capture (
	input wire logic clock,
	input wire logic rstn,
	input wire logic fire,
	output logic sample_clk,
	output logic busy,
	input wire logic [9:0] word,
	input wire logic flag,
	output logic [10:0] cap,
	output logic [7:0] cap_n,
	output logic cap_ok
);
	logic [2:0] ph;
	// clock high two cycles, then low and still until the next burst
	assign sample_clk = (ph == 3'h1) || (ph == 3'h2);
	assign busy = (ph != 3'h0);
	// words of the first five edges are stale
	assign cap_ok = (cap_n > 8'h05);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ph <= 3'h0;
			cap <= 11'h000;
			cap_n <= 8'h00;
		end else begin
			if (ph != 3'h0) begin
				ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
			end else if (fire) begin
				ph <= 3'h1;
			end
			if (ph == 3'h3) begin
				cap <= {flag, word};
				cap_n <= cap_n + 8'h01;
			end
		end
	end
endmodule : paso_capture

// File: paso_adc_out_test.sv
// self-checking bench of the sample output block with its capture partner
`timescale 1ns/10ps
module paso_adc_out_test;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic fire = 1'b0;
	logic over_top = 1'b0;
	logic under_bottom = 1'b0;
	logic stream_ready = 1'b0;
	logic stream_lost_clear = 1'b0;
	logic [4:0] coarse_code = 5'h00;
	logic [5:0] fine_code = 6'h00;
	logic track_hold, coarse_go, fine_go, sample_bit_top, range_flag;
	logic stream_valid, stream_room, stream_lost, sample_clk, busy, cap_ok;
	logic [9:0] sample_word;
	logic [10:0] stream_data, cap;
	logic [7:0] cap_n;
	logic [10:0] exq[$];
	int fails = 0;
	int checks = 0;

	always #25 clock = ~clock;

	paso_adc_out dut (.clock(clock), .rstn(rstn), .sample_clk(sample_clk),
		.over_top(over_top), .under_bottom(under_bottom), .coarse_code(coarse_code),
		.fine_code(fine_code), .track_hold(track_hold), .coarse_go(coarse_go),
		.fine_go(fine_go), .sample_word(sample_word), .sample_bit_top(sample_bit_top),
		.range_flag(range_flag), .stream_data(stream_data), .stream_valid(stream_valid),
		.stream_ready(stream_ready), .stream_room(stream_room),
		.stream_lost_clear(stream_lost_clear), .stream_lost(stream_lost));

	paso_capture partner (.clock(clock), .rstn(rstn), .fire(fire), .sample_clk(sample_clk),
		.busy(busy), .word(sample_word), .flag(range_flag), .cap(cap), .cap_n(cap_n),
		.cap_ok(cap_ok));

	task wrap_up;
		if (fails == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up

	task chk(input string nm, input logic [10:0] e, input logic [10:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// pipeline holds zeros for the first five edges
	function logic [10:0] stale(input int k);
		return (k < 5) ? 11'h000 : exq[k - 5];
	endfunction : stale

	task smp(input logic ov, input logic un, input logic [4:0] c, input logic [5:0] f);
		int i;
		int w;
		logic [4:0] vh, vc, vf;
		logic [10:0] e;
		w = int'(c) * 32 + int'(f) - 16;
		if (w < 0) w = 0;
		if (w > 1023) w = 1023;
		exq.push_back(ov ? 11'h7ff : (un ? 11'h400 : {1'b0, w[9:0]}));
		over_top = ov;
		under_bottom = un;
		coarse_code = c;
		fine_code = f;
		fire = 1'b1;
		for (i = 0; i < 5; i++) begin
			@(negedge clock);
			fire = 1'b0;
			vh[i] = track_hold;
			vc[i] = coarse_go;
			vf[i] = fine_go;
		end
		chk("hold", 11'h00e, {6'h00, vh});
		chk("coarse", 11'h002, {6'h00, vc});
		chk("fine", 11'h004, {6'h00, vf});
		i = 0;
		while (busy) begin
			@(negedge clock);
			i++;
			if (i > 20) begin
				fails++;
				wrap_up();
			end
		end
		e = stale(int'(cap_n) - 1);
		if (cap_ok) chk("capture", e, cap);
		chk("pins", e, {range_flag, sample_word});
		chk("msb", {10'h000, e[9]}, {10'h000, sample_bit_top});
	endtask : smp

	task drain;
		int i;
		for (i = 0; i < 16; i++) begin
			@(negedge clock);
			chk("valid", 11'h001, {10'h000, stream_valid});
			chk("stream", stale(i), stream_data);
			stream_ready = 1'b1;
		end
		@(negedge clock);
		stream_ready = 1'b0;
		chk("empty", 11'h000, {10'h000, stream_valid});
	endtask : drain

	initial begin
		int i;
		repeat (10) @(negedge clock);
		rstn = 1'b1;
		@(negedge clock);
		chk("reset", 11'h002, {7'h00, track_hold, stream_valid, stream_room, stream_lost});
		chk("reset word", 11'h000, {range_flag, sample_word});
		smp(1'b0, 1'b0, 5'h0f, 6'h2f);
		smp(1'b1, 1'b0, 5'h0f, 6'h2f);
		smp(1'b0, 1'b1, 5'h1f, 6'h3f);
		smp(1'b1, 1'b1, 5'h00, 6'h00);
		smp(1'b0, 1'b0, 5'h00, 6'h00);
		smp(1'b0, 1'b0, 5'h1f, 6'h3f);
		smp(1'b0, 1'b0, 5'h03, 6'h05);
		for (i = 0; i < 10; i++) begin
			smp(1'b0, 1'b0, 5'(i * 3), 6'(i * 7));
		end
		chk("full", 11'h001, {9'h000, stream_room, stream_lost});
		drain();
		stream_lost_clear = 1'b1;
		@(negedge clock);
		stream_lost_clear = 1'b0;
		@(negedge clock);
		chk("lost", 11'h002, {9'h000, stream_room, stream_lost});
		wrap_up();
	end
endmodule : paso_adc_out_test
